// [design/lsu_pkg.sv]
// Package of constants and types for the load/store sequencing block
package lsu_pkg;

    // ------------------------------------------------------------
    // Operation classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LSU_OP_LOAD = 4'h0,
        LSU_OP_STORE = 4'h1,
        LSU_OP_LOAD_MULTI = 4'h2,
        LSU_OP_STORE_MULTI = 4'h3,
        LSU_OP_LOAD_MULTI_DW = 4'h4,
        LSU_OP_LOAD_STR_IMM = 4'h5,
        LSU_OP_LOAD_STR_IDX = 4'h6,
        LSU_OP_STORE_STR_IMM = 4'h7,
        LSU_OP_STORE_STR_IDX = 4'h8,
        LSU_OP_FLOAT_STORE_SINGLE = 4'h9
    } lsu_op_t;

    // ------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LSU_ST_IDLE = 4'h1,
        LSU_ST_START = 4'h2,
        LSU_ST_XFER = 4'h4,
        LSU_ST_DONE = 4'h8
    } lsu_state_t;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int LSU_ADDR_W = 64;
    localparam int LSU_REG_W = 5;
    localparam int LSU_NUM_GPR = 32;
    localparam int LSU_DATA_W = 64;
    localparam int LSU_SQ_DEPTH = 32;
    localparam int LSU_SQ_CNT_W = 6;
    localparam int LSU_STORE_BYTES = 8;
    localparam int LSU_START_DELAY = 2;
    localparam int LSU_PAGE_BITS = 12;
    localparam logic [3:0] LSU_WORD_MASK = 4'h3;
    localparam logic [3:0] LSU_DWORD_MASK = 4'h7;
    localparam logic [10:0] LSU_FS_EXP_MIN = 11'h36a;
    localparam int LSU_FS_SIGN_POS = 63;
    localparam int LSU_FS_EXP_HI = 62;
    localparam int LSU_FS_EXP_LO = 52;
    localparam int LSU_FS_LOWFRAC_HI = 54;
    localparam int LSU_FS_LOWFRAC_LO = 32;

endpackage

// [design/lsu_seq.sv]
// Load/store sequencer: alignment checks, register sequencing, store queue
`timescale 1ns/10ps
module lsu_seq
    import lsu_pkg::*;
#(
    parameter int SQ_DEPTH = lsu_pkg::LSU_SQ_DEPTH,
    parameter int START_DELAY = lsu_pkg::LSU_START_DELAY
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic issue_valid,
    input wire lsu_pkg::lsu_op_t issue_op,
    input wire logic [lsu_pkg::LSU_ADDR_W-1:0] effective_address,
    input wire logic [3:0] access_size,
    input wire logic cache_inhibited,
    input wire logic update_form,
    input wire logic [lsu_pkg::LSU_REG_W-1:0] target_register_field,
    input wire logic [lsu_pkg::LSU_REG_W-1:0] base_register_field,
    input wire logic [lsu_pkg::LSU_REG_W-1:0] index_register_field,
    input wire logic [6:0] string_length,
    input wire logic [lsu_pkg::LSU_DATA_W-1:0] float_source_register,
    input wire logic first_page_fault,
    input wire logic second_page_fault,
    input wire logic async_interrupt,
    input wire logic cache_store_ready,
    output logic issue_ready,
    output logic align_interrupt,
    output logic storage_interrupt,
    output logic restart_required,
    output logic gpr_write_valid,
    output logic [lsu_pkg::LSU_REG_W-1:0] gpr_write_index,
    output logic gpr_write_is_address,
    output logic gpr_write_undefined,
    output logic [1:0] xfer_count,
    output logic [lsu_pkg::LSU_REG_W-1:0] xfer_first_reg,
    output logic store_data_valid,
    output logic [lsu_pkg::LSU_DATA_W-1:0] store_data,
    output logic cache_store_valid,
    output logic [lsu_pkg::LSU_SQ_CNT_W-1:0] queue_count
);
    import lsu_pkg::*;

    // ------------------------------------------------------------
    // Issue decode
    // ------------------------------------------------------------
    logic is_multi;
    logic is_string;
    logic is_load;
    logic misaligned;
    logic align_fault;
    logic page_cross;
    logic [LSU_REG_W-1:0] clip_src;
    logic [5:0] reg_span;
    logic [5:0] clip_span;
    logic [5:0] xfer_total;
    logic [10:0] fs_exp;

    always_comb
    begin
        is_multi = (issue_op == LSU_OP_LOAD_MULTI)
            || (issue_op == LSU_OP_STORE_MULTI)
            || (issue_op == LSU_OP_LOAD_MULTI_DW);
        is_string = (issue_op == LSU_OP_LOAD_STR_IMM)
            || (issue_op == LSU_OP_LOAD_STR_IDX)
            || (issue_op == LSU_OP_STORE_STR_IMM)
            || (issue_op == LSU_OP_STORE_STR_IDX);
        is_load = (issue_op == LSU_OP_LOAD)
            || (issue_op == LSU_OP_LOAD_MULTI)
            || (issue_op == LSU_OP_LOAD_MULTI_DW)
            || (issue_op == LSU_OP_LOAD_STR_IMM)
            || (issue_op == LSU_OP_LOAD_STR_IDX);
        // Single access misaligned against its own size
        misaligned = (effective_address[3:0]
            & (access_size - 4'h1)) != 4'h0;
        page_cross = (effective_address[LSU_PAGE_BITS-1:0]
            + {8'h00, access_size}) > 13'h1000 ? 1'b1 : 1'b0;
        align_fault = 1'b0;
        unique case (issue_op)
            LSU_OP_LOAD:
                align_fault = cache_inhibited && misaligned;
            LSU_OP_STORE, LSU_OP_FLOAT_STORE_SINGLE:
                align_fault = cache_inhibited && misaligned;
            LSU_OP_LOAD_MULTI, LSU_OP_STORE_MULTI:
                align_fault = cache_inhibited
                    || ((effective_address[3:0] & LSU_WORD_MASK)
                    != 4'h0);
            LSU_OP_LOAD_MULTI_DW:
                align_fault = cache_inhibited
                    || ((effective_address[3:0] & LSU_DWORD_MASK)
                    != 4'h0);
            default:
                align_fault = cache_inhibited;
        endcase
        // Registers from target to 31 for multiples
        reg_span = 6'h20 - {1'b0, target_register_field};
        // Strings move four bytes per register, rounded up; one spare bit
        // keeps lengths near 127 from wrapping to a short transfer
        xfer_total = is_string
            ? 6'(({1'b0, string_length} + 8'h3) >> 2) : reg_span;
        // Overlap clipping source register
        if (issue_op == LSU_OP_LOAD_STR_IDX && base_register_field != 5'h0)
            clip_src = (base_register_field < index_register_field)
                ? base_register_field : index_register_field;
        else if (issue_op == LSU_OP_LOAD_STR_IDX)
            clip_src = index_register_field;
        else
            clip_src = base_register_field;
        clip_span = {1'b0, clip_src} - {1'b0, target_register_field};
        if ((issue_op == LSU_OP_LOAD_STR_IDX
            || (issue_op == LSU_OP_LOAD_STR_IMM
            && base_register_field != 5'h0))
            && clip_src >= target_register_field
            && {1'b0, clip_src} < {1'b0, target_register_field}
            + xfer_total)
            xfer_total = clip_span;
        if (issue_op == LSU_OP_STORE_STR_IMM
            || issue_op == LSU_OP_STORE_STR_IDX
            || issue_op == LSU_OP_LOAD_STR_IMM
            || issue_op == LSU_OP_LOAD_STR_IDX)
            if (string_length == 7'h0)
                xfer_total = 6'h0;
        fs_exp = float_source_register[LSU_FS_EXP_HI:LSU_FS_EXP_LO];
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    lsu_state_t state_reg, state_next;
    logic [3:0] delay_reg, delay_next;
    logic [5:0] left_reg, left_next;
    logic [LSU_REG_W-1:0] reg_ptr_reg, reg_ptr_next;
    logic load_reg, load_next;
    logic ready_reg, ready_next;
    logic align_reg, align_next;
    logic stint_reg, stint_next;
    logic restart_reg, restart_next;
    logic gw_reg, gw_next;
    logic [LSU_REG_W-1:0] gwi_reg, gwi_next;
    logic gwa_reg, gwa_next;
    logic gwu_reg, gwu_next;
    logic [1:0] xc_reg, xc_next;
    logic [LSU_REG_W-1:0] xf_reg, xf_next;
    logic sdv_reg, sdv_next;
    logic [LSU_DATA_W-1:0] sd_reg, sd_next;
    logic [LSU_SQ_CNT_W-1:0] qc_reg, qc_next;
    logic csv_reg, csv_next;
    logic [1:0] room;
    logic [1:0] push;
    logic drain;

    // Next-state: drain runs independently of the sequencer
    always_comb
    begin
        state_next = state_reg;
        delay_next = delay_reg;
        left_next = left_reg;
        reg_ptr_next = reg_ptr_reg;
        load_next = load_reg;
        align_next = 1'b0;
        stint_next = 1'b0;
        restart_next = 1'b0;
        gw_next = 1'b0;
        gwi_next = gwi_reg;
        gwa_next = 1'b0;
        gwu_next = 1'b0;
        xc_next = 2'h0;
        xf_next = xf_reg;
        sdv_next = 1'b0;
        sd_next = sd_reg;
        push = 2'h0;
        drain = csv_reg && cache_store_ready;
        room = (qc_reg <= 6'(SQ_DEPTH - 2)) ? 2'h2
            : (qc_reg == 6'(SQ_DEPTH - 1)) ? 2'h1 : 2'h0;
        ready_next = 1'b0;
        unique case (state_reg)
            LSU_ST_IDLE:
            begin
                // A single store pushes unchecked, so hold off on a full queue
                ready_next = room != 2'h0;
                if (issue_valid && ready_reg)
                begin
                    ready_next = 1'b0;
                    if (align_fault)
                    begin
                        // Raised before any register or queue effect
                        align_next = 1'b1;
                        state_next = LSU_ST_DONE;
                    end
                    else if (!is_multi && !is_string
                        && (first_page_fault
                        || (page_cross && second_page_fault)))
                    begin
                        // Whole single access suppressed
                        stint_next = 1'b1;
                        state_next = LSU_ST_DONE;
                    end
                    else if (is_multi || is_string)
                    begin
                        // Restart always recomputes from current base
                        delay_next = 4'(START_DELAY);
                        left_next = xfer_total;
                        reg_ptr_next = target_register_field;
                        load_next = is_load;
                        state_next = LSU_ST_START;
                    end
                    else
                    begin
                        if (update_form)
                        begin
                            // Address always wins over returned data
                            gw_next = 1'b1;
                            gwi_next = base_register_field;
                            gwa_next = 1'b1;
                        end
                        else if (is_load)
                        begin
                            gw_next = 1'b1;
                            gwi_next = target_register_field;
                        end
                        if (!is_load)
                        begin
                            push = 2'h1;
                            sdv_next = 1'b1;
                            sd_next = float_source_register;
                            if (issue_op == LSU_OP_FLOAT_STORE_SINGLE
                                && fs_exp < LSU_FS_EXP_MIN
                                && float_source_register[LSU_FS_LOWFRAC_HI:
                                LSU_FS_LOWFRAC_LO] != 23'h0)
                                sd_next = {float_source_register[
                                    LSU_FS_SIGN_POS], 63'h0};
                        end
                        state_next = LSU_ST_DONE;
                    end
                end
            end
            LSU_ST_START:
            begin
                // Template start-up cost
                if (delay_reg <= 4'h1)
                    state_next = LSU_ST_XFER;
                delay_next = delay_reg - 4'h1;
            end
            LSU_ST_XFER:
            begin
                if (async_interrupt || second_page_fault)
                begin
                    // No partial resume; stores stop before next page
                    restart_next = async_interrupt;
                    stint_next = second_page_fault;
                    gwu_next = load_reg;
                    state_next = LSU_ST_DONE;
                end
                else if (left_reg == 6'h0)
                    state_next = LSU_ST_DONE;
                else if (load_reg || room != 2'h0)
                begin
                    // Two registers per cycle when space allows
                    xc_next = (left_reg >= 6'h2 && (load_reg
                        || room == 2'h2)) ? 2'h2 : 2'h1;
                    xf_next = reg_ptr_reg;
                    reg_ptr_next = reg_ptr_reg + 5'(xc_next);
                    left_next = left_reg - 6'(xc_next);
                    if (!load_reg)
                        push = xc_next;
                    sdv_next = !load_reg;
                end
            end
            LSU_ST_DONE:
                state_next = LSU_ST_IDLE;
            default:
                state_next = LSU_ST_IDLE;
        endcase
        qc_next = qc_reg + 6'(push) - 6'(drain);
        csv_next = qc_next != 6'h0;
    end

    // Register stage
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_reg <= LSU_ST_IDLE;
            delay_reg <= 4'h0;
            left_reg <= 6'h0;
            reg_ptr_reg <= 5'h0;
            load_reg <= 1'b0;
            ready_reg <= 1'b0;
            align_reg <= 1'b0;
            stint_reg <= 1'b0;
            restart_reg <= 1'b0;
            gw_reg <= 1'b0;
            gwi_reg <= 5'h0;
            gwa_reg <= 1'b0;
            gwu_reg <= 1'b0;
            xc_reg <= 2'h0;
            xf_reg <= 5'h0;
            sdv_reg <= 1'b0;
            sd_reg <= 64'h0;
            qc_reg <= 6'h0;
            csv_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            delay_reg <= delay_next;
            left_reg <= left_next;
            reg_ptr_reg <= reg_ptr_next;
            load_reg <= load_next;
            ready_reg <= ready_next;
            align_reg <= align_next;
            stint_reg <= stint_next;
            restart_reg <= restart_next;
            gw_reg <= gw_next;
            gwi_reg <= gwi_next;
            gwa_reg <= gwa_next;
            gwu_reg <= gwu_next;
            xc_reg <= xc_next;
            xf_reg <= xf_next;
            sdv_reg <= sdv_next;
            sd_reg <= sd_next;
            qc_reg <= qc_next;
            csv_reg <= csv_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign issue_ready = ready_reg;
    assign align_interrupt = align_reg;
    assign storage_interrupt = stint_reg;
    assign restart_required = restart_reg;
    assign gpr_write_valid = gw_reg;
    assign gpr_write_index = gwi_reg;
    assign gpr_write_is_address = gwa_reg;
    assign gpr_write_undefined = gwu_reg;
    assign xfer_count = xc_reg;
    assign xfer_first_reg = xf_reg;
    assign store_data_valid = sdv_reg;
    assign store_data = sd_reg;
    assign cache_store_valid = csv_reg;
    assign queue_count = qc_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_align_single;
        @(posedge clock) disable iff (reset)
        issue_valid && issue_ready && issue_op == LSU_OP_LOAD
            && cache_inhibited && misaligned |=> align_interrupt;
    endproperty
    a_align_single: assert property (p_align_single)
        else $error("misaligned inhibited load without alignment");

    property p_align_store;
        @(posedge clock) disable iff (reset)
        issue_valid && issue_ready && issue_op == LSU_OP_STORE
            && cache_inhibited && misaligned
            |=> align_interrupt && !store_data_valid;
    endproperty
    a_align_store: assert property (p_align_store)
        else $error("misaligned inhibited store not refused");

    property p_align_multi;
        @(posedge clock) disable iff (reset)
        issue_valid && issue_ready && is_multi && cache_inhibited
            |=> align_interrupt;
    endproperty
    a_align_multi: assert property (p_align_multi)
        else $error("inhibited multiple without alignment");

    property p_align_word;
        @(posedge clock) disable iff (reset)
        issue_valid && issue_ready && issue_op == LSU_OP_STORE_MULTI
            && effective_address[1:0] != 2'h0 |=> align_interrupt;
    endproperty
    a_align_word: assert property (p_align_word)
        else $error("unaligned multiple without alignment");

    property p_align_first;
        @(posedge clock) disable iff (reset)
        align_interrupt |-> !gpr_write_valid && !store_data_valid;
    endproperty
    a_align_first: assert property (p_align_first)
        else $error("update visible with alignment interrupt");

    property p_suppress_single;
        @(posedge clock) disable iff (reset)
        issue_valid && issue_ready && issue_op == LSU_OP_LOAD
            && !align_fault && first_page_fault
            |=> storage_interrupt && !gpr_write_valid;
    endproperty
    a_suppress_single: assert property (p_suppress_single)
        else $error("faulting load left a result");

    property p_queue_bound;
        @(posedge clock) disable iff (reset)
        queue_count <= 6'(SQ_DEPTH);
    endproperty
    a_queue_bound: assert property (p_queue_bound)
        else $error("store queue overfilled");

    property p_start_delay;
        @(posedge clock) disable iff (reset)
        issue_valid && issue_ready && (is_multi || is_string)
            && !align_fault |=> xfer_count == 2'h0 [*2];
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("transfer began before start-up delay");

    property p_update_zero;
        @(posedge clock) disable iff (reset)
        issue_valid && issue_ready && update_form && !is_multi
            && !is_string && !align_fault && !first_page_fault
            && !(page_cross && second_page_fault)
            && base_register_field == 5'h0
            |=> gpr_write_valid && gpr_write_index == 5'h0
            && gpr_write_is_address;
    endproperty
    a_update_zero: assert property (p_update_zero)
        else $error("update form did not write address");

    property p_restart;
        @(posedge clock) disable iff (reset)
        state_reg == LSU_ST_XFER && async_interrupt
            |=> restart_required ##1 state_reg == LSU_ST_IDLE;
    endproperty
    a_restart: assert property (p_restart)
        else $error("interrupted sequence did not end for restart");

endmodule

// [test/lsu_cache_model.sv]
// Data cache drain side model for the load/store sequencer bench
`timescale 1ns/10ps
module lsu_cache_model
(
    input wire logic clock,
    input wire logic reset,
    input wire logic cache_store_valid,
    output logic cache_store_ready
);
    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    logic [15:0] drained_reg;
    logic [15:0] drained_next;

    // ------------------------------------------------------------
    // Drain pacing
    // ------------------------------------------------------------
    // Stall two cycles in eight so the queue backs up between drains
    always_comb
    begin
        phase_next = phase_reg + 3'h1;
        drained_next = drained_reg;
        if (cache_store_valid && cache_store_ready)
            drained_next = drained_reg + 16'h1;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            phase_reg <= 3'h0;
            drained_reg <= 16'h0;
        end
        else
        begin
            phase_reg <= phase_next;
            drained_reg <= drained_next;
        end
    end

    // At most one 8-byte store taken per cycle
    assign cache_store_ready = ~reset && (phase_reg[2:1] != 2'b11);
endmodule

// [test/lsu_seq_tb_top.sv]
// Scoreboard testbench for the load/store sequencer
`timescale 1ns/10ps
module lsu_seq_tb_top;
    import lsu_pkg::*;
    typedef logic [73:0] lsu_ev_t;
    localparam lsu_ev_t align_ev = {1'b1, 73'h0};
    localparam lsu_ev_t storage_ev = {2'b01, 72'h0};
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic issue_valid = 1'b0;
    lsu_op_t issue_op = LSU_OP_LOAD;
    logic [63:0] effective_address = 64'h0;
    logic [3:0] access_size = 4'h8;
    logic cache_inhibited = 1'b0;
    logic update_form = 1'b0;
    logic [4:0] target_register_field = 5'h0;
    logic [4:0] base_register_field = 5'h0;
    logic [4:0] index_register_field = 5'h0;
    logic [6:0] string_length = 7'h0;
    logic [63:0] float_source_register = 64'h0;
    logic first_page_fault = 1'b0;
    logic second_page_fault = 1'b0;
    logic async_interrupt = 1'b0;
    logic cache_store_ready;
    logic issue_ready, align_interrupt, storage_interrupt, restart_required;
    logic gpr_write_valid, gpr_write_is_address, gpr_write_undefined;
    logic [4:0] gpr_write_index, xfer_first_reg;
    logic [1:0] xfer_count;
    logic store_data_valid, cache_store_valid;
    logic [63:0] store_data;
    logic [5:0] queue_count;
    lsu_ev_t notes[$];
    lsu_ev_t seen;
    int mismatches = 0;
    int total_checks = 0;
    int xfer_sum = 0;
    int xfer_cycles = 0;
    int first_sum = 0;
    int restarts = 0;
    logic [31:0] seed = 32'hd34a;
    int i;

    lsu_seq i_lsu_seq (.clock, .reset, .issue_valid, .issue_op,
        .effective_address, .access_size, .cache_inhibited, .update_form,
        .target_register_field, .base_register_field, .index_register_field,
        .string_length, .float_source_register, .first_page_fault,
        .second_page_fault, .async_interrupt, .cache_store_ready,
        .issue_ready, .align_interrupt, .storage_interrupt,
        .restart_required, .gpr_write_valid, .gpr_write_index,
        .gpr_write_is_address, .gpr_write_undefined, .xfer_count,
        .xfer_first_reg, .store_data_valid, .store_data,
        .cache_store_valid, .queue_count);

    lsu_cache_model i_lsu_cache_model (.clock, .reset, .cache_store_valid,
        .cache_store_ready);

    always #5 clock = ~clock;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic check(input lsu_ev_t got, input lsu_ev_t exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Flags are {inhibited, update, first fault, second fault}
    task automatic issue(input lsu_op_t op, input logic [63:0] a,
        input logic [3:0] sz, input logic [4:0] tr, input logic [4:0] br,
        input logic [3:0] fl, input logic [63:0] fs, input int n,
        input lsu_ev_t e);
        int k;
        k = 0;
        @(posedge clock);
        // Bounded wait: a stuck ready must not hang the run
        while (issue_ready !== 1'b1 && k < 200)
        begin
            @(posedge clock);
            k++;
        end
        if (k == 200)
            mismatches++;
        issue_valid <= 1'b1;
        issue_op <= op;
        effective_address <= a;
        access_size <= sz;
        string_length <= {3'h0, sz};
        target_register_field <= tr;
        base_register_field <= br;
        index_register_field <= tr + 5'h1;
        {cache_inhibited, update_form} <= fl[3:2];
        {first_page_fault, second_page_fault} <= fl[1:0];
        float_source_register <= fs;
        if (n > 0)
            notes.push_back(e);
        @(posedge clock);
        issue_valid <= 1'b0;
    endtask

    // Result monitor: every pulse takes the oldest note, or is checked against zero when no note is queued
    always @(posedge clock)
    begin
        seen = {align_interrupt, storage_interrupt, gpr_write_valid,
            gpr_write_valid ? gpr_write_index : 5'h0,
            gpr_write_valid & gpr_write_is_address, store_data_valid,
            store_data_valid ? store_data : 64'h0};
        // Tallies of sequenced transfers and broken-off sequences
        if (!reset)
        begin
            xfer_sum += xfer_count;
            xfer_cycles += int'(xfer_count != 2'h0);
            first_sum += (xfer_count != 2'h0) ? xfer_first_reg : 0;
            restarts += int'(restart_required && gpr_write_undefined);
        end
        if (!reset && seen[73:64] !== 10'h0)
        begin
            if (notes.size() == 0)
                check(seen, 74'h0);
            else
                check(seen, notes.pop_front());
        end
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        // Misaligned accesses to inhibited storage
        issue(LSU_OP_LOAD, 64'h1001, 4'h4, 5'h3, 5'h1, 4'h8, 64'h0, 1,
            align_ev);
        issue(LSU_OP_STORE, 64'h1002, 4'h8, 5'h3, 5'h1, 4'h8, 64'h5, 1,
            align_ev);
        // Page-crossing faults, first and second page
        issue(LSU_OP_LOAD, 64'h1ffe, 4'h4, 5'h3, 5'h1, 4'h2, 64'h0, 1,
            storage_ev);
        issue(LSU_OP_LOAD, 64'h1ffe, 4'h4, 5'h3, 5'h1, 4'h1, 64'h0, 1,
            storage_ev);
        issue(LSU_OP_STORE, 64'h2ffc, 4'h8, 5'h3, 5'h1, 4'h1, 64'h9, 1,
            storage_ev);
        // Multi-register alignment and inhibited storage
        issue(LSU_OP_LOAD_MULTI, 64'h1002, 4'h4, 5'h1c, 5'h1, 4'h0, 64'h0,
            1, align_ev);
        issue(LSU_OP_STORE_MULTI, 64'h1000, 4'h4, 5'h1c, 5'h1, 4'h8,
            64'h0, 1, align_ev);
        issue(LSU_OP_LOAD_MULTI_DW, 64'h1004, 4'h8, 5'h1c, 5'h1, 4'h0,
            64'h0, 1, align_ev);
        // Every string form to inhibited storage
        for (i = 5; i < 9; i++)
            issue(lsu_op_t'(i), 64'h1000, 4'h8, 5'h4, 5'h1, 4'h8, 64'h0, 1,
                align_ev);
        // Zero-length string load must write nothing
        issue(LSU_OP_LOAD_STR_IMM, 64'h1000, 4'h0, 5'h4, 5'h1, 4'h0, 64'h0,
            0, 74'h0);
        // Overlap clipping: indexed keeps one register, immediate none
        issue(LSU_OP_LOAD_STR_IDX, 64'h1000, 4'h8, 5'h4, 5'h0, 4'h0, 64'h0,
            0, 74'h0);
        issue(LSU_OP_LOAD_STR_IMM, 64'h1000, 4'h8, 5'h4, 5'h4, 4'h0, 64'h0,
            0, 74'h0);
        // Six registers two at a time, then the same load broken off
        issue(LSU_OP_LOAD_MULTI, 64'h1000, 4'h4, 5'h1a, 5'h1, 4'h0, 64'h0,
            0, 74'h0);
        issue(LSU_OP_LOAD_MULTI, 64'h1000, 4'h4, 5'h1a, 5'h1, 4'h0, 64'h0,
            0, 74'h0);
        async_interrupt <= 1'b1;
        repeat (6) @(posedge clock);
        async_interrupt <= 1'b0;
        // Update form, base zero equal to target: address into GPR0
        issue(LSU_OP_LOAD, 64'h1008, 4'h8, 5'h0, 5'h0, 4'h4, 64'h0, 1,
            {3'b001, 5'h0, 1'b1, 65'h0});
        // Random aligned loads and tiny single float stores
        for (i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            issue(LSU_OP_LOAD, {29'h0, seed, 3'h0}, 4'h8, seed[4:0],
                seed[9:5], 4'h0, 64'h0, 1, {3'b001, seed[4:0], 66'h0});
            issue(LSU_OP_FLOAT_STORE_SINGLE, {30'h0, seed, 2'h0}, 4'h4,
                5'h2, 5'h1, 4'h0, {seed[31], 3'h1, seed[7:0], 19'h0, 1'b1,
                seed}, 1, {9'h0, 1'b1, seed[31], 63'h0});
        end
        repeat (20) @(posedge clock);
        if (notes.size() != 0)
            mismatches++;
        // Transfer totals, restart count and the drained queue
        check(74'(xfer_sum), 74'h7);
        check(74'(xfer_cycles), 74'h4);
        check(74'(first_sum), 74'h58);
        check(74'(restarts), 74'h1);
        check(74'(i_lsu_cache_model.drained_reg), 74'h8);
        check(74'({cache_store_valid, queue_count}), 74'h0);
        report_and_stop();
    end
endmodule
